// *** homing_params.svh ***
// Constants for the homing sequencer and quadrature counter.
// Assumes inclusion by the package and by every design module.
// Notes on behaviour
// - Stop signal comes from one selected source: limit switch, revolution sensor or sync input.
// - A disabled sync input is ignored, so it never yields a stop.
// - Standard homing moves at homing speed and direction until the stop.
// - After the final stop, absolute move at working speed to standoff; that is home.
// - Second phase, when enabled, moves with its own settings to its own stop.
// - Second phase speed, direction and source are separate from the first phase.
// - Half-turn option delays second-phase stop watching by half a revolution.
// - Home resolves to one microstep (1/256 step) or one encoder count.
// - Fast homing first moves at working speed in the set direction to the stop.
// - Fast homing then backs off half a turn, then approaches at homing speed.
// - Fast homing starts the standoff move only after the second stop.
// - Fast homing uses the first-phase stop source.
// - Successful homing sets the homed flag.
// - Homed flag clears on limit stop, moving immediate stop, lost steps or alarm.
// - Immediate stop or power-off while stationary keeps the homed flag.
// - Encoder is decoded four-edge: four counts per signal period.
// - Counter keeps up with 200 kHz single-ended and 5 MHz differential per channel.
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH
`define POS_W 40
`define SPEED_W 24
`define MICROSTEPS_PER_STEP 256
`define SRC_LIMIT 2'h0
`define SRC_REV 2'h1
`define SRC_SYNC 2'h2
`define CLK_HZ 100000000
`define ENC_MAX_HZ 5000000
`endif

// *** homing_pkg.sv ***
// Types shared by the homing sequencer and its helpers.
// Assumes homing_params.svh is on the include path.
`include "homing_params.svh"
package homing_pkg;
	typedef logic [1:0] stop_src_t;
	typedef logic signed [`POS_W-1:0] pos_t;
	typedef logic [`SPEED_W-1:0] speed_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FIRST = 3'b001,
		ST_BACKOFF = 3'b010,
		ST_REAPPROACH = 3'b011,
		ST_SECOND = 3'b100,
		ST_STANDOFF = 3'b101
	} home_state_e;
endpackage : homing_pkg

// *** stop_select.sv ***
// Stop-signal source selector with rising-edge detection.
// Assumes source levels already carry their own polarity configuration.
`include "homing_params.svh"
module stop_select (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Sources
	input wire logic limit_active_i,
	input wire logic rev_sensor_active_i,
	input wire logic sync_in_i,
	input wire logic sync_enable_i,
	// Selection
	input wire homing_pkg::stop_src_t src_i,
	input wire logic arm_i,
	// Result
	output logic stop_o
);
	import homing_pkg::*;
	typedef struct packed {
		logic prev;
	} sel_s;
	sel_s r, next_r;
	logic level;
	always_comb begin
		unique case (src_i)
			`SRC_LIMIT: level = limit_active_i;
			`SRC_REV: level = rev_sensor_active_i;
			`SRC_SYNC: level = sync_in_i & sync_enable_i;
			default: level = 1'b0;
		endcase
		next_r.prev = arm_i ? level : 1'b1;
	end
	// Edge only while armed, so a level already present at arming is not taken
	assign stop_o = arm_i & level & ~r.prev;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '{prev: 1'b1};
		end else begin
			r <= next_r;
		end
	end
endmodule : stop_select

// *** quad_counter.sv ***
// Four-edge quadrature position counter.
// Assumes encoder inputs are already synchronous and filtered.
`include "homing_params.svh"
module quad_counter #(
	parameter int POS_W = `POS_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Encoder
	input wire logic quad_phase_first_i,
	input wire logic quad_phase_second_i,
	// Position load
	input wire logic load_i,
	input wire logic signed [POS_W-1:0] load_value_i,
	// Count
	output logic signed [POS_W-1:0] count_o
);
	import homing_pkg::*;
	initial begin
		if (POS_W < 8) $error("quad_counter: POS_W too small");
		// 100 MHz samples each 5 MHz channel 20 times per period
		if (`CLK_HZ < 8 * `ENC_MAX_HZ) $error("quad_counter: clock too slow");
	end
	typedef struct packed {
		logic a;
		logic b;
		logic signed [POS_W-1:0] cnt;
	} quad_s;
	quad_s r, next_r;
	always_comb begin
		next_r = r;
		next_r.a = quad_phase_first_i;
		next_r.b = quad_phase_second_i;
		if (load_i) begin
			next_r.cnt = load_value_i;
		// Every single edge counts; a both-channel change is ambiguous
		end else if ((r.a ^ quad_phase_first_i) ^ (r.b ^ quad_phase_second_i)) begin
			// First channel leads when its new level differs from the old second level
			if (quad_phase_first_i ^ r.b) begin
				next_r.cnt = r.cnt + POS_W'(1);
			end else begin
				next_r.cnt = r.cnt - POS_W'(1);
			end
		end
	end
	assign count_o = r.cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule : quad_counter

// *** homing_sequencer.sv ***
// Homing sequencer with quadrature position counter.
// Assumes the motion engine executes move commands and reports completion.
`include "homing_params.svh"
module homing_sequencer #(
	parameter int POS_W = `POS_W,
	parameter int SPEED_W = `SPEED_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Command
	input wire logic home_start_i,
	input wire logic fast_homing_i,
	input wire logic second_phase_en_i,
	input wire logic half_turn_en_i,
	// First phase settings
	input wire logic first_dir_i,
	input wire homing_pkg::speed_t first_speed_i,
	input wire homing_pkg::stop_src_t first_src_i,
	// Second phase settings
	input wire logic second_dir_i,
	input wire homing_pkg::speed_t second_speed_i,
	input wire homing_pkg::stop_src_t second_src_i,
	// Motion settings
	input wire homing_pkg::speed_t working_speed_i,
	input wire homing_pkg::pos_t standoff_i,
	input wire homing_pkg::pos_t half_turn_i,
	// Stop sources
	input wire logic limit_active_i,
	input wire logic rev_sensor_active_i,
	input wire logic sync_in_i,
	input wire logic sync_enable_i,
	// Position feedback
	input wire logic use_encoder_i,
	input wire homing_pkg::pos_t step_pos_i,
	input wire logic quad_phase_first_i,
	input wire logic quad_phase_second_i,
	// Motion engine
	input wire logic move_done_i,
	input wire logic moving_i,
	output logic move_run_o,
	output logic move_abs_o,
	output logic move_dir_o,
	output homing_pkg::speed_t move_speed_o,
	output homing_pkg::pos_t move_target_o,
	output logic move_stop_o,
	// Loss-of-home events
	input wire logic limit_stop_i,
	input wire logic immediate_stop_i,
	input wire logic power_off_i,
	input wire logic steps_lost_i,
	input wire logic alarm_i,
	// Status
	output homing_pkg::pos_t position_o,
	output logic homing_busy_o,
	output logic homed_flag_o
);
	import homing_pkg::*;
	initial begin
		if (POS_W != `POS_W) $error("homing_sequencer: POS_W must match package");
		if (SPEED_W != `SPEED_W) $error("homing_sequencer: SPEED_W must match package");
	end
	typedef struct packed {
		home_state_e st;
		logic homed;
		logic run;
		logic abs_mode;
		logic dir;
		speed_t speed;
		pos_t target;
		logic stop_cmd;
		pos_t mark;
		logic watch;
	} seq_s;
	seq_s r, next_r;
	logic stop_hit;
	stop_src_t cur_src;
	logic arm;
	pos_t enc_count;
	pos_t pos;
	pos_t travel;

	// Position in microsteps or encoder counts, whichever feeds back
	assign pos = use_encoder_i ? enc_count : step_pos_i;

	quad_counter #(
		.POS_W(POS_W)
	) u_quad (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.quad_phase_first_i(quad_phase_first_i),
		.quad_phase_second_i(quad_phase_second_i),
		.load_i(1'b0),
		.load_value_i('0),
		.count_o(enc_count)
	);

	// Second phase has its own source; all other phases use the first
	assign cur_src = (r.st == ST_SECOND) ? second_src_i : first_src_i;
	assign arm = r.watch && (r.st == ST_FIRST || r.st == ST_REAPPROACH || r.st == ST_SECOND);

	stop_select u_stop (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.limit_active_i(limit_active_i),
		.rev_sensor_active_i(rev_sensor_active_i),
		.sync_in_i(sync_in_i),
		.sync_enable_i(sync_enable_i),
		.src_i(cur_src),
		.arm_i(arm),
		.stop_o(stop_hit)
	);

	function automatic pos_t abs_diff(input pos_t a, input pos_t b);
		pos_t d;
		d = a - b;
		return d[POS_W-1] ? -d : d;
	endfunction : abs_diff

	assign travel = abs_diff(pos, r.mark);

	always_comb begin
		next_r = r;
		next_r.stop_cmd = 1'b0;
		unique case (r.st)
			ST_IDLE: begin
				next_r.run = 1'b0;
				if (home_start_i && !alarm_i) begin
					next_r.st = ST_FIRST;
					next_r.run = 1'b1;
					next_r.abs_mode = 1'b0;
					next_r.dir = first_dir_i;
					next_r.watch = 1'b1;
					next_r.homed = 1'b0;
					if (fast_homing_i) begin
						next_r.speed = working_speed_i;
					end else begin
						next_r.speed = first_speed_i;
					end
				end
			end
			ST_FIRST: begin
				if (stop_hit) begin
					next_r.mark = pos;
					if (fast_homing_i) begin
						// Back off half a turn against the search direction
						next_r.st = ST_BACKOFF;
						next_r.abs_mode = 1'b0;
						next_r.dir = ~first_dir_i;
						next_r.speed = working_speed_i;
						next_r.watch = 1'b0;
					end else if (second_phase_en_i) begin
						next_r.st = ST_SECOND;
						next_r.dir = second_dir_i;
						next_r.speed = second_speed_i;
						next_r.watch = ~half_turn_en_i;
					end else begin
						next_r.st = ST_STANDOFF;
					end
				end
			end
			ST_BACKOFF: begin
				if (travel >= half_turn_i) begin
					next_r.st = ST_REAPPROACH;
					next_r.dir = first_dir_i;
					next_r.speed = first_speed_i;
					next_r.watch = 1'b1;
				end
			end
			ST_REAPPROACH: begin
				if (stop_hit) begin
					next_r.mark = pos;
					if (second_phase_en_i) begin
						next_r.st = ST_SECOND;
						next_r.dir = second_dir_i;
						next_r.speed = second_speed_i;
						next_r.watch = ~half_turn_en_i;
					end else begin
						next_r.st = ST_STANDOFF;
					end
				end
			end
			ST_SECOND: begin
				// Stops from the first phase can repeat here, so wait half a turn
				if (!r.watch && travel >= half_turn_i) begin
					next_r.watch = 1'b1;
				end
				if (stop_hit) begin
					next_r.mark = pos;
					next_r.st = ST_STANDOFF;
				end
			end
			ST_STANDOFF: begin
				if (move_done_i && r.abs_mode) begin
					next_r.st = ST_IDLE;
					next_r.run = 1'b0;
					next_r.homed = 1'b1;
				end
			end
			default: next_r.st = ST_IDLE;
		endcase
		// Standoff is an absolute move from the reference point
		if (next_r.st == ST_STANDOFF && r.st != ST_STANDOFF) begin
			next_r.abs_mode = 1'b1;
			next_r.speed = working_speed_i;
			next_r.target = next_r.mark + standoff_i;
			next_r.watch = 1'b0;
		end
		// Home is lost on limit stop, lost steps or alarm, and on immediate stop or power-off only while moving
		if (limit_stop_i || (immediate_stop_i && moving_i) || steps_lost_i || alarm_i) begin
			next_r.homed = 1'b0;
		end
		if (power_off_i && moving_i) begin
			next_r.homed = 1'b0;
		end
		if (alarm_i && r.st != ST_IDLE) begin
			next_r.st = ST_IDLE;
			next_r.run = 1'b0;
			next_r.watch = 1'b0;
			next_r.stop_cmd = 1'b1;
			next_r.homed = 1'b0;
		end
	end

	assign move_run_o = r.run;
	assign move_abs_o = r.abs_mode;
	assign move_dir_o = r.dir;
	assign move_speed_o = r.speed;
	assign move_target_o = r.target;
	assign move_stop_o = r.stop_cmd;
	assign position_o = pos;
	assign homing_busy_o = (r.st != ST_IDLE);
	assign homed_flag_o = r.homed;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '{st: ST_IDLE, default: '0};
		end else begin
			r <= next_r;
		end
	end
endmodule : homing_sequencer

// *** homing_sequencer_asserts.sv ***
// Port assertions for the homing sequencer.
// Assumes a bind onto homing_sequencer; one clock domain.
module homing_sequencer_asserts import homing_pkg::*; (
	// Inputs watched
	input wire logic clk_i, rst_i, home_start_i, alarm_i, moving_i, move_done_i,
	input wire logic limit_stop_i, immediate_stop_i, power_off_i, steps_lost_i, use_encoder_i,
	input wire pos_t step_pos_i,
	// Outputs watched
	input wire logic move_run_o, move_abs_o, move_stop_o, homing_busy_o, homed_flag_o,
	input wire pos_t position_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_start_runs: assert property (home_start_i && !homing_busy_o && !alarm_i |=> move_run_o && homing_busy_o)
		else $error("start not taken");
	a_alarm_abort: assert property (homing_busy_o && alarm_i |=> !homing_busy_o && !homed_flag_o && move_stop_o)
		else $error("alarm did not abort");
	a_loss_clears: assert property (limit_stop_i || steps_lost_i || alarm_i || (immediate_stop_i && moving_i)
		|=> !homed_flag_o) else $error("homed kept after loss");
	a_still_keeps: assert property (homed_flag_o && !moving_i && !limit_stop_i && !steps_lost_i && !alarm_i
		&& !home_start_i |=> homed_flag_o) else $error("homed dropped while still");
	a_homed_rise: assert property ($rose(homed_flag_o) |-> $past(move_done_i) && !homing_busy_o)
		else $error("homed without completion");
	a_homed_cause: assert property (!homed_flag_o && !(homing_busy_o && move_abs_o && move_done_i) |=> !homed_flag_o)
		else $error("homed set without offset move");
	a_step_pos: assert property (!use_encoder_i |-> position_o == step_pos_i)
		else $error("step position not passed");
	a_stop_pulse: assert property (move_stop_o |=> !move_stop_o)
		else $error("stop pulse too long");
	c_homed: cover property ($rose(homed_flag_o));
	c_abort: cover property (homing_busy_o && alarm_i);
	c_keep: cover property (homed_flag_o && immediate_stop_i && !moving_i);
endmodule : homing_sequencer_asserts
bind homing_sequencer homing_sequencer_asserts homing_sequencer_asserts_inst (.clk_i, .rst_i, .home_start_i,
	.alarm_i, .moving_i, .move_done_i, .limit_stop_i, .immediate_stop_i, .power_off_i, .steps_lost_i,
	.use_encoder_i, .step_pos_i, .move_run_o, .move_abs_o, .move_stop_o, .homing_busy_o, .homed_flag_o,
	.position_o);

// *** motion_partner.sv ***
// Far-side model: motion engine and quadrature encoder.
// Assumes one encoder request per cycle at most.
module motion_partner (
	input wire logic clk_i, rst_i, run_i, abs_i, hold_i, step_i, dir_i, glitch_i,
	output logic done_o, moving_o, first_o, second_o
);
	logic [3:0] cnt;
	logic [1:0] ph;
	// Slow answer: absolute moves take six cycles
	assign done_o = cnt == 4'h6;
	assign moving_o = run_i | hold_i;
	assign first_o = ph[1] ^ ph[0];
	assign second_o = ph[1];
	always_ff @(posedge clk_i) begin
		if (rst_i || !(run_i && abs_i)) cnt <= 4'h0;
		else if (cnt != 4'hf) cnt <= cnt + 4'h1;
		if (rst_i) ph <= 2'h0;
		else if (glitch_i) ph <= ph + 2'h2;
		else if (step_i) ph <= dir_i ? ph + 2'h1 : ph - 2'h1;
	end
endmodule : motion_partner

// *** tb_top.sv ***
// Self-checking bench for the homing sequencer.
// Assumes motion_partner stands in for engine and encoder.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import homing_pkg::*;
	logic clk_i = 0, rst_i = 1, home_start_i = 0, fast_homing_i = 0, second_phase_en_i = 0, half_turn_en_i = 0;
	logic first_dir_i = 0, second_dir_i = 0, limit_active_i = 0, rev_sensor_active_i = 0, sync_in_i = 0;
	logic sync_enable_i = 1, use_encoder_i = 0, hold = 0, step = 0, dir = 0, glitch = 0;
	logic limit_stop_i = 0, immediate_stop_i = 0, power_off_i = 0, steps_lost_i = 0, alarm_i = 0;
	logic move_done_i, moving_i, quad_phase_first_i, quad_phase_second_i;
	logic move_run_o, move_abs_o, move_dir_o, move_stop_o, homing_busy_o, homed_flag_o;
	speed_t first_speed_i = 0, second_speed_i = 0, working_speed_i = 0, move_speed_o;
	stop_src_t first_src_i = 0, second_src_i = 0;
	pos_t standoff_i = 0, half_turn_i = 40'h64, step_pos_i = 0, move_target_o, position_o;
	int miscompares = 0, tests_run = 0, cycles = 0;
	logic [31:0] seed = 32'h15870;
	logic [31:0] r;
	homing_sequencer homing_sequencer_inst (.clk_i, .rst_i, .home_start_i, .fast_homing_i, .second_phase_en_i,
		.half_turn_en_i, .first_dir_i, .first_speed_i, .first_src_i, .second_dir_i, .second_speed_i, .second_src_i,
		.working_speed_i, .standoff_i, .half_turn_i, .limit_active_i, .rev_sensor_active_i, .sync_in_i,
		.sync_enable_i, .use_encoder_i, .step_pos_i, .quad_phase_first_i, .quad_phase_second_i, .move_done_i,
		.moving_i, .move_run_o, .move_abs_o, .move_dir_o, .move_speed_o, .move_target_o, .move_stop_o,
		.limit_stop_i, .immediate_stop_i, .power_off_i, .steps_lost_i, .alarm_i, .position_o, .homing_busy_o,
		.homed_flag_o);
	motion_partner motion_partner_inst (.clk_i, .rst_i, .run_i(move_run_o), .abs_i(move_abs_o), .hold_i(hold),
		.step_i(step), .dir_i(dir), .glitch_i(glitch), .done_o(move_done_i), .moving_o(moving_i),
		.first_o(quad_phase_first_i), .second_o(quad_phase_second_i));
	always #5 clk_i = ~clk_i;
	// Whole run is near 340 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			summarize();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic stop_src_t other(input stop_src_t s);
		return s == 2'h2 ? 2'h0 : s + 2'h1;
	endfunction : other
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc
	task automatic chk_bit(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_bit
	task automatic chk_val(input string nm, input logic [39:0] e, input logic [39:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_val
	task automatic pulse(input stop_src_t s);
		limit_active_i = s == 2'h0;
		rev_sensor_active_i = s == 2'h1;
		sync_in_i = s == 2'h2;
		cyc(1);
		{limit_active_i, rev_sensor_active_i, sync_in_i} = 3'h0;
		cyc(3);
	endtask : pulse
	task automatic enc(input logic d, input logic g);
		dir = d;
		glitch = g;
		step = !g;
		cyc(1);
		{step, glitch} = 2'h0;
		cyc(4);
	endtask : enc
	task automatic home(input logic f, input logic s, input logic h);
		fast_homing_i = f;
		second_phase_en_i = s;
		half_turn_en_i = h;
		r = rnd();
		{first_dir_i, second_dir_i, first_src_i, second_src_i} = {r[1:0], r[3:2] % 2'h3, r[5:4] % 2'h3};
		first_speed_i = r[31:8];
		r = rnd();
		{second_speed_i, working_speed_i} = {r[23:0], r[31:8]};
		r = rnd();
		{standoff_i, step_pos_i} = {8'h0, r, 8'h0, r ^ 32'h5a5a5a5a};
		home_start_i = 1;
		cyc(1);
		home_start_i = 0;
		cyc(1);
		chk_bit("run", 1, move_run_o);
		chk_bit("dir", first_dir_i, move_dir_o);
		chk_val("speed", {16'h0, f ? working_speed_i : first_speed_i}, {16'h0, move_speed_o});
		sync_enable_i = 0;
		pulse(2'h2);
		pulse(other(first_src_i));
		chk_bit("held", first_dir_i, move_dir_o);
		sync_enable_i = 1;
		pulse(first_src_i);
		if (f) begin
			chk_bit("back", !first_dir_i, move_dir_o);
			step_pos_i = first_dir_i ? step_pos_i - half_turn_i : step_pos_i + half_turn_i;
			for (int i = 0; i < 40 && move_dir_o !== first_dir_i; i++) cyc(1);
			chk_val("again", {16'h0, first_speed_i}, {16'h0, move_speed_o});
			pulse(second_src_i == first_src_i ? other(first_src_i) : second_src_i);
			chk_bit("no_stand", 0, move_abs_o);
			pulse(first_src_i);
		end
		if (s) begin
			chk_bit("dir2", second_dir_i, move_dir_o);
			chk_val("speed2", {16'h0, second_speed_i}, {16'h0, move_speed_o});
			if (h) begin
				pulse(second_src_i);
				chk_bit("early", 0, move_abs_o);
				step_pos_i = step_pos_i + half_turn_i;
				cyc(2);
			end
			pulse(second_src_i);
		end
		chk_bit("abs", 1, move_abs_o);
		chk_val("wspeed", {16'h0, working_speed_i}, {16'h0, move_speed_o});
		chk_val("target", step_pos_i + standoff_i, move_target_o);
		for (int i = 0; i < 40 && homed_flag_o !== 1'b1; i++) cyc(1);
		chk_bit("homed", 1, homed_flag_o);
		chk_bit("idle", 0, homing_busy_o);
	endtask : home
	initial begin
		repeat (16) @(posedge clk_i);
		cyc(1);
		rst_i = 0;
		cyc(2);
		use_encoder_i = 1;
		r = rnd();
		for (int i = 0; i < r[3:0] + 4; i++) enc(1, 0);
		enc(0, 1);
		for (int i = 0; i < 3; i++) enc(0, 0);
		chk_val("count", 40'(r[3:0] + 1), position_o);
		use_encoder_i = 0;
		for (int k = 0; k < 8; k++) begin
			home(k[0], k[1], k[2]);
			{immediate_stop_i, power_off_i} = 2'h3;
			cyc(1);
			{immediate_stop_i, power_off_i} = 2'h0;
			cyc(1);
			chk_bit("keep", 1, homed_flag_o);
			hold = k % 4 == 3;
			{limit_stop_i, steps_lost_i, alarm_i, immediate_stop_i} = 4'h8 >> (k % 4);
			cyc(1);
			{limit_stop_i, steps_lost_i, alarm_i, immediate_stop_i, hold} = 5'h0;
			cyc(1);
			chk_bit("lost", 0, homed_flag_o);
		end
		home_start_i = 1;
		cyc(1);
		home_start_i = 0;
		cyc(3);
		alarm_i = 1;
		cyc(1);
		alarm_i = 0;
		chk_bit("mstop", 1, move_stop_o);
		cyc(1);
		chk_bit("abort", 0, homing_busy_o);
		chk_bit("unhomed", 0, homed_flag_o);
		summarize();
	end
endmodule : tb_top
